// ===== design/tbwdt_defs.vh
// timebase and watchdog constants: offsets, fields, reset values, taps
// assumes inclusion by bare name from the design files
`ifndef TBWDT_DEFS_VH
`define TBWDT_DEFS_VH
// ****************************************
// register offsets (word index on the plain port)
// ****************************************
`define TBWDT_ADDR_W 3
`define TBWDT_OFS_TB_CTRL 3'h0
`define TBWDT_OFS_WDT_CTRL 3'h1
`define TBWDT_OFS_IRQ_STAT 3'h2
`define TBWDT_OFS_IRQ_MASK 3'h3
`define TBWDT_OFS_TB_COUNT 3'h4
// ****************************************
// field positions
// ****************************************
`define TBWDT_TB_SEL_LO 0
`define TBWDT_TB_SEL_HI 1
`define TBWDT_TB_CLR_BIT 2
`define TBWDT_OSC_SEL_LO 3
`define TBWDT_OSC_SEL_HI 4
`define TBWDT_WDT_SEL_LO_BIT 0
`define TBWDT_WDT_SEL_HI_BIT 1
`define TBWDT_WDT_CLR_BIT 2
`define TBWDT_WDT_RUN_BIT 3
`define TBWDT_WDT_CNT_LO 4
`define TBWDT_WDT_CNT_HI 5
`define TBWDT_IRQ_TB_BIT 0
`define TBWDT_IRQ_OSC_BIT 1
// ****************************************
// reset values
// ****************************************
`define TBWDT_TB_CTRL_RST 5'h00
`define TBWDT_WDT_SEL_RST 2'h0
`define TBWDT_IRQ_STAT_RST 2'h0
`define TBWDT_IRQ_MASK_RST 2'h0
// ****************************************
// timebase taps (bit index whose carry marks a period of 2^(n+1))
// ****************************************
`define TBWDT_TAP_2P12 11
`define TBWDT_TAP_2P13 12
`define TBWDT_TAP_2P14 13
`define TBWDT_TAP_2P15 14
`define TBWDT_TAP_2P16 15
`define TBWDT_TAP_2P18 17
`define TBWDT_TAP_2P19 18
`define TBWDT_TB_W 18
`define TBWDT_WDT_W 2
`define TBWDT_WDT_RST_PULSE 4'h4
`endif

// ===== design/tbwdt_dog.v
// two-bit watchdog counting carries of a selected timebase tap
// assumes carry pulses are one clk cycle long; picks one of the four by sel_ff
`timescale 1ns/10ps
`include "tbwdt_defs.vh"
module tbwdt_dog #(
  parameter CNT_W = `TBWDT_WDT_W,
  parameter PULSE_LEN = `TBWDT_WDT_RST_PULSE
) (
  input wire clk,
  input wire nrst,
  input wire por_clr,
  input wire soft_clr,
  input wire clr_event,
  input wire [1:0] sel_in,
  input wire [3:0] carry_in,
  output wire running,
  output wire [1:0] sel_out,
  output wire [CNT_W-1:0] count,
  output wire wdt_reset
);
  reg run_ff;
  reg [1:0] sel_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg [3:0] pulse_ff;
  reg [CNT_W-1:0] nxt_cnt;
  wire carry;
  wire expire;
  assign carry = carry_in[sel_ff];
  assign expire = run_ff & carry & (&cnt_ff) & ~soft_clr & ~clr_event;
  always @* begin
    nxt_cnt = cnt_ff;
    if (soft_clr | clr_event | ~run_ff) begin
      nxt_cnt = {CNT_W{1'b0}};
    end else if (carry) begin
      nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge clk) begin
    if (!nrst || por_clr) begin
      run_ff <= 1'b0;
      sel_ff <= `TBWDT_WDT_SEL_RST;
      cnt_ff <= {CNT_W{1'b0}};
      pulse_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (soft_clr && !run_ff) begin
        run_ff <= 1'b1;
        sel_ff <= sel_in;
      end
      if (expire) begin
        run_ff <= 1'b0;
        pulse_ff <= PULSE_LEN;
      end else if (pulse_ff != 4'h0) begin
        pulse_ff <= pulse_ff - 4'h1;
      end
    end
  end
  assign running = run_ff;
  assign sel_out = sel_ff;
  assign count = cnt_ff;
  assign wdt_reset = (pulse_ff != 4'h0);
endmodule

// ===== design/tbwdt_top.v
// timebase counter with interval interrupt, clock taps and watchdog
// assumes a plain register port, one clock, synchronous active-low reset
// Operation
// - 18-bit timebase counts up freely, once per clock
// - interval tap overflow raises a timebase interrupt request, repeating
// - interval select picks 2^12, 2^14, 2^16 or 2^19 cycles
// - stabilization wait tap: 2^13, 2^15 or 2^18 cycles
// - watchdog count clock from taps 2^12, 2^14, 2^16, 2^19
// - timebase taps also drive the time clock output
// - watchdog is a two-bit counter advanced by selected carry
// - started watchdog resets the cpu when not cleared in time
// - select 00..11 gives timeout 2^14, 2^16, 2^18, 2^21 cycles
// - only nrst, power-on or its own reset stops the watchdog
// - external, internal reset, clear bit, sleep or stop clear count
// - clearing keeps selection and keeps the watchdog running
// - clearing timebase drops carry progress, lengthening the timeout
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "tbwdt_defs.vh"
module tbwdt_top #(
  parameter TB_W = `TBWDT_TB_W
) (
  input wire clk,
  input wire nrst,
  input wire por,
  input wire ext_int_reset,
  input wire sleep_enter,
  input wire stop_enter,
  input wire [`TBWDT_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output wire [7:0] rdata,
  output wire irq,
  output wire osc_stab_done,
  output wire [3:0] clk_out_taps,
  output wire cpu_reset
);
  // ****************************************
  // registers
  // ****************************************
  reg [TB_W-1:0] tb_ff;
  reg [4:0] tb_ctrl_ff;
  reg [1:0] wdt_sel_ff;
  reg [1:0] stat_ff;
  reg [1:0] mask_ff;
  reg [7:0] rdata_ff;
  reg [TB_W-1:0] nxt_tb;
  reg [7:0] nxt_rdata;
  wire [TB_W-1:0] tb_inc;
  wire [TB_W-1:0] carry;
  wire tb_clr;
  wire wdt_clr;
  wire wr_tb;
  wire wr_wdt;
  wire wr_stat;
  wire wr_mask;
  wire tb_evt;
  wire osc_evt;
  wire wdt_run;
  wire [1:0] wdt_sel_live;
  wire [1:0] wdt_cnt;
  wire wdt_rst;
  reg iv_carry;
  reg osc_carry;
  reg tb_top_ff;
  reg skip_ff;
  reg nxt_skip;
  wire [3:0] dog_taps;
  wire [3:0] half_taps;
  wire [1:0] dog_sel;
  wire dog_clr;
  assign wr_tb = wr && (addr == `TBWDT_OFS_TB_CTRL);
  assign wr_wdt = wr && (addr == `TBWDT_OFS_WDT_CTRL);
  assign wr_stat = wr && (addr == `TBWDT_OFS_IRQ_STAT);
  assign wr_mask = wr && (addr == `TBWDT_OFS_IRQ_MASK);
  assign tb_clr = wr_tb && wdata[`TBWDT_TB_CLR_BIT];
  assign wdt_clr = wr_wdt && wdata[`TBWDT_WDT_CLR_BIT];
  // ****************************************
  // timebase counter and carries
  // ****************************************
  assign tb_inc = tb_ff + {{(TB_W-1){1'b0}}, 1'b1};
  genvar gi;
  generate
    for (gi = 0; gi < TB_W; gi = gi + 1) begin : g_carry
      assign carry[gi] = (&tb_ff[gi:0]) & ~tb_clr;
    end
  endgenerate
  always @* begin
    nxt_tb = tb_inc;
    if (tb_clr) begin
      nxt_tb = {TB_W{1'b0}};
    end
  end
  always @(posedge clk) begin
    if (!nrst) begin
      tb_ff <= {TB_W{1'b0}};
      tb_top_ff <= 1'b0;
    end else begin
      tb_ff <= nxt_tb;
      tb_top_ff <= tb_clr ? 1'b0 : (tb_top_ff ^ (&tb_ff));
    end
  end
  // top tap: counter overflow divided once more by the extra stage
  wire carry_2p19;
  assign carry_2p19 = (&tb_ff) & tb_top_ff & ~tb_clr;
  always @* begin
    case (tb_ctrl_ff[`TBWDT_TB_SEL_HI:`TBWDT_TB_SEL_LO])
      2'h0: iv_carry = carry[`TBWDT_TAP_2P12];
      2'h1: iv_carry = carry[`TBWDT_TAP_2P14];
      2'h2: iv_carry = carry[`TBWDT_TAP_2P16];
      2'h3: iv_carry = carry_2p19;
      default: iv_carry = 1'b0;
    endcase
  end
  always @* begin
    case (tb_ctrl_ff[`TBWDT_OSC_SEL_HI:`TBWDT_OSC_SEL_LO])
      2'h0: osc_carry = carry[`TBWDT_TAP_2P13];
      2'h1: osc_carry = carry[`TBWDT_TAP_2P15];
      2'h2: osc_carry = carry[`TBWDT_TAP_2P18];
      2'h3: osc_carry = carry[`TBWDT_TAP_2P18];
      default: osc_carry = 1'b0;
    endcase
  end
  assign tb_evt = iv_carry;
  assign osc_evt = osc_carry;
  assign clk_out_taps = {carry_2p19, carry[`TBWDT_TAP_2P16],
    carry[`TBWDT_TAP_2P14], carry[`TBWDT_TAP_2P12]};
  // ****************************************
  // control, status and mask registers
  // ****************************************
  always @(posedge clk) begin
    if (!nrst) begin
      tb_ctrl_ff <= `TBWDT_TB_CTRL_RST;
      wdt_sel_ff <= `TBWDT_WDT_SEL_RST;
      stat_ff <= `TBWDT_IRQ_STAT_RST;
      mask_ff <= `TBWDT_IRQ_MASK_RST;
    end else begin
      if (wr_tb) begin
        tb_ctrl_ff <= {wdata[`TBWDT_OSC_SEL_HI:`TBWDT_OSC_SEL_LO], 1'b0,
          wdata[`TBWDT_TB_SEL_HI:`TBWDT_TB_SEL_LO]};
      end
      if (wr_wdt) begin
        wdt_sel_ff <= wdata[`TBWDT_WDT_SEL_HI_BIT:`TBWDT_WDT_SEL_LO_BIT];
      end
      if (wr_mask) begin
        mask_ff <= wdata[1:0];
      end
      // set wins over the write-one clear
      stat_ff[`TBWDT_IRQ_TB_BIT] <= tb_evt |
        (stat_ff[`TBWDT_IRQ_TB_BIT] & ~(wr_stat & wdata[`TBWDT_IRQ_TB_BIT]));
      stat_ff[`TBWDT_IRQ_OSC_BIT] <= osc_evt |
        (stat_ff[`TBWDT_IRQ_OSC_BIT] & ~(wr_stat & wdata[`TBWDT_IRQ_OSC_BIT]));
    end
  end
  assign irq = |(stat_ff & mask_ff);
  assign osc_stab_done = stat_ff[`TBWDT_IRQ_OSC_BIT];
  // ****************************************
  // watchdog
  // ****************************************
  assign dog_taps = {carry_2p19, carry[`TBWDT_TAP_2P16], carry[`TBWDT_TAP_2P14],
    carry[`TBWDT_TAP_2P12]};
  assign half_taps = {tb_top_ff, tb_ff[`TBWDT_TAP_2P16], tb_ff[`TBWDT_TAP_2P14],
    tb_ff[`TBWDT_TAP_2P12]};
  assign dog_sel = wdt_run ? wdt_sel_live :
    wdata[`TBWDT_WDT_SEL_HI_BIT:`TBWDT_WDT_SEL_LO_BIT];
  assign dog_clr = wdt_clr | ext_int_reset | sleep_enter | stop_enter;
  // a clear in the late half of a tap period skips the next carry
  always @* begin
    nxt_skip = skip_ff;
    if (dog_clr) begin
      nxt_skip = half_taps[dog_sel] & ~dog_taps[dog_sel];
    end else if (dog_taps[wdt_sel_live]) begin
      nxt_skip = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (!nrst || por) begin
      skip_ff <= 1'b0;
    end else begin
      skip_ff <= nxt_skip;
    end
  end
  tbwdt_dog tbwdt_dog_inst (
    .clk(clk),
    .nrst(nrst),
    .por_clr(por),
    .soft_clr(wdt_clr),
    .clr_event(ext_int_reset | sleep_enter | stop_enter),
    .sel_in(wdata[`TBWDT_WDT_SEL_HI_BIT:`TBWDT_WDT_SEL_LO_BIT]),
    .carry_in(dog_taps & {4{~skip_ff}}),
    .running(wdt_run),
    .sel_out(wdt_sel_live),
    .count(wdt_cnt),
    .wdt_reset(wdt_rst)
  );
  assign cpu_reset = wdt_rst;
  // ****************************************
  // read port
  // ****************************************
  always @* begin
    nxt_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `TBWDT_OFS_TB_CTRL: nxt_rdata = {3'h0, tb_ctrl_ff};
        `TBWDT_OFS_WDT_CTRL: nxt_rdata = {2'h0, wdt_cnt, wdt_run, 1'b0,
          (wdt_run ? wdt_sel_live : wdt_sel_ff)};
        `TBWDT_OFS_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
        `TBWDT_OFS_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
        `TBWDT_OFS_TB_COUNT: nxt_rdata = tb_ff[TB_W-1:TB_W-8];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end
  always @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;
endmodule

// ===== dv/tbwdt_monitor.sv
// checker on the tbwdt_top ports
// assumes binding onto tbwdt_top, one clock, sync active-low reset
`timescale 1ns/10ps
module tbwdt_monitor #(
  parameter TB_W = 18
) (
  input wire clk,
  input wire nrst,
  input wire por,
  input wire ext_int_reset,
  input wire sleep_enter,
  input wire stop_enter,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire irq,
  input wire osc_stab_done,
  input wire [3:0] clk_out_taps,
  input wire cpu_reset
);
  // ****************************************
  // tap spacing and watchdog checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reg [12:0] gap_ff;
  reg seen_ff;
  always @(posedge clk) begin
    if (!nrst) begin
      gap_ff <= 13'h0000;
      seen_ff <= 1'b0;
    end else if (clk_out_taps[0]) begin
      gap_ff <= 13'h0000;
      seen_ff <= 1'b1;
    end else if (gap_ff != 13'h1FFF) begin
      gap_ff <= gap_ff + 13'h0001;
    end
  end
  AST_TAP0_GAP: assert property (clk_out_taps[0] && seen_ff |-> gap_ff >= 13'h0FFF)
    else $error("tap pulse too early");
  AST_TAP1_NEST: assert property (clk_out_taps[1] |-> clk_out_taps[0])
    else $error("tap 1 without tap 0");
  AST_TAP2_NEST: assert property (clk_out_taps[2] |-> clk_out_taps[1])
    else $error("tap 2 without tap 1");
  AST_TAP3_NEST: assert property (clk_out_taps[3] |-> clk_out_taps[2])
    else $error("tap 3 without tap 2");
  AST_RST_LEN: assert property ($rose(cpu_reset) |-> cpu_reset[*4] ##1 !cpu_reset)
    else $error("cpu reset pulse length wrong");
  AST_RST_CAUSE: assert property ($rose(cpu_reset) |-> $past(|clk_out_taps))
    else $error("cpu reset without a carry");
  AST_CLR_HOLD: assert property (ext_int_reset || sleep_enter || stop_enter
    |-> ##2 !$rose(cpu_reset))
    else $error("cpu reset right after a clear");
  AST_POR_STOP: assert property (por |=> !cpu_reset)
    else $error("cpu reset pulse survives power-on reset");
  AST_WDT_CLR_RD: assert property (rd && addr == 3'h1 |=> !rdata[2])
    else $error("watchdog clear bit reads one");
  AST_TB_CLR_RD: assert property (rd && addr == 3'h0 |=> !rdata[2])
    else $error("timebase clear bit reads one");
endmodule
bind tbwdt_top tbwdt_monitor #(.TB_W(TB_W)) tbwdt_monitor_inst (
  .clk(clk), .nrst(nrst), .por(por), .ext_int_reset(ext_int_reset),
  .sleep_enter(sleep_enter), .stop_enter(stop_enter), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .osc_stab_done(osc_stab_done),
  .clk_out_taps(clk_out_taps), .cpu_reset(cpu_reset)
);

// ===== dv/test_timebase_and_watchdog.sv
// self-checking bench for tbwdt_top
// assumes the checker binds itself from its own file
`timescale 1ns/10ps
module test_timebase_and_watchdog;
  reg clk = 1'b0, nrst = 1'b0, por = 1'b0, ext_int_reset = 1'b0;
  reg sleep_enter = 1'b0, stop_enter = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg [7:0] v, v0;
  wire [7:0] rdata;
  wire irq, osc_stab_done, cpu_reset;
  wire [3:0] clk_out_taps;
  integer fail_count = 0, compares = 0, cyc = 0, t0, n, i, rst_cnt = 0, n0 = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cpu_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  tbwdt_top tbwdt_top_inst (
    .clk(clk), .nrst(nrst), .por(por), .ext_int_reset(ext_int_reset),
    .sleep_enter(sleep_enter), .stop_enter(stop_enter), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .osc_stab_done(osc_stab_done),
    .clk_out_taps(clk_out_taps), .cpu_reset(cpu_reset)
  );
  // ****************************************
  // bus tasks and checks
  // ****************************************
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task in_rng(input integer x, input integer lo, input integer hi);
    check(x >= lo && x <= hi, 1);
  endtask
  task report_and_stop;
    begin
      $display("fail_count=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [2:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
    end
  endtask
  task pulse(input integer k);
    begin
      @(posedge clk);
      case (k)
        0: ext_int_reset <= 1'b1;
        1: sleep_enter <= 1'b1;
        2: stop_enter <= 1'b1;
        default: por <= 1'b1;
      endcase
      @(posedge clk);
      {por, ext_int_reset, sleep_enter, stop_enter} <= 4'h0;
    end
  endtask
  task wait_for(input integer k);
    begin
      n = 0;
      #1;
      while ((k == 0 ? irq : k == 1 ? osc_stab_done : cpu_reset) !== 1'b1) begin
        @(posedge clk);
        #1 n = n + 1;
        if (n > 20000) begin
          fail_count = fail_count + 1;
          report_and_stop;
        end
      end
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      rd_reg(i[2:0]);
      check(v, 0);
    end
    rd_reg(3'h4);
    v0 = v;
    repeat (1022) @(posedge clk);
    rd_reg(3'h4);
    check(v, v0 + 8'h01);
    wr_reg(3'h3, 8'h01);
    for (i = 0; i < 2; i = i + 1) begin
      wr_reg(3'h0, 8'h04 | i[7:0]);
      wr_reg(3'h2, 8'h03);
      if (i == 1) begin
        wait_for(1);
        in_rng(n, 8184, 8196);
      end
      wait_for(0);
      in_rng(n, (4096 << 2 * i) - 8 - 8192 * i, (4096 << 2 * i) + 4 - 8192 * i);
    end
    wr_reg(3'h3, 8'h00);
    #1 check(irq, 0);
    rd_reg(3'h2);
    check(v & 8'h01, 1);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h3, 8'h01);
    #1 check(irq, 0);
    wr_reg(3'h0, 8'h04);
    wr_reg(3'h1, 8'h04);
    t0 = cyc;
    rd_reg(3'h1);
    check(v & 8'h0F, 8'h08);
    repeat (4200) @(posedge clk);
    rd_reg(3'h1);
    check(v & 8'h38, 8'h18);
    wait_for(2);
    in_rng(cyc - t0, 14336, 18432);
    rd_reg(3'h1);
    check(v & 8'h38, 0);
    repeat (2056) @(posedge clk);
    wr_reg(3'h1, 8'h04);
    n0 = rst_cnt;
    for (i = 0; i < 4; i = i + 1) begin
      repeat (9216) @(posedge clk);
      if (i < 3)
        pulse(i);
      else
        wr_reg(3'h1, 8'h07);
    end
    check(rst_cnt - n0, 0);
    t0 = cyc;
    wait_for(2);
    in_rng(cyc - t0, 14336, 18440);
    repeat (8) @(posedge clk);
    wr_reg(3'h1, 8'h04);
    pulse(3);
    rd_reg(3'h1);
    check(v & 8'h08, 0);
    report_and_stop;
  end
endmodule
